// File: osdp_pkg.sv
/*
  Constants, register map and carrier types for the output stage
  divider with duty-cycle shaping and coarse phase stepping.
  Assumes a single source clock from the assigned fractional divider.
*/
// Overview of operation
// RULE_01 - two identical paths share one source clock
// RULE_02 - divide source clock by 32-bit integer ratio
// RULE_03 - zero high width gives 50/50 duty
// RULE_04 - nonzero high width sets exact high cycles
// RULE_05 - software keeps high width below ratio
// RULE_06 - pulses always high-going; invert complement for low
// RULE_07 - duty adjustment available in every mode
// RULE_08 - per-output coarse step in whole source cycles
// RULE_09 - never shorten below two high, two low
// RULE_10 - software avoids coarse step for ratio 1-4
// RULE_11 - one step moves each portion at most 2^32
// RULE_12 - signed step applied within one period, clamped
// RULE_13 - 50/50 path splits step between high, low
// RULE_14 - pulse path applies step to low only
// RULE_15 - software splits large moves into smaller steps
// RULE_16 - per-output complement inversion option
// RULE_17 - count from period start, high first then low
// RULE_18 - new step taken at next boundary, once
package osdp_pkg;

  localparam int          OSDP_NUM_PATHS  = 2;
  localparam int          OSDP_RATIO_W    = 32;
  localparam int          OSDP_LEN_W      = 34;
  localparam int          OSDP_ADDR_W     = 8;
  localparam int          OSDP_DATA_W     = 32;

  // per-path register block, stride in bytes
  localparam logic [7:0]  OSDP_PATH_STRIDE = 8'h20;
  localparam logic [7:0]  OSDP_OFS_RATIO   = 8'h00;
  localparam logic [7:0]  OSDP_OFS_HIGH    = 8'h04;
  localparam logic [7:0]  OSDP_OFS_STEP    = 8'h08;
  localparam logic [7:0]  OSDP_OFS_CTRL    = 8'h0C;
  localparam logic [7:0]  OSDP_OFS_STATUS  = 8'h10;
  localparam logic [7:0]  OSDP_OFS_MASK    = 8'h1F;
  localparam int          OSDP_PATH_LSB    = 5;

  // field positions
  localparam int          OSDP_CTRL_INV_BIT     = 0;
  localparam int          OSDP_STAT_PEND_BIT    = 0;
  localparam int          OSDP_STAT_LEVEL_BIT   = 1;

  // reset values
  localparam logic [31:0] OSDP_RATIO_RST  = 32'h0000_0002;
  localparam logic [31:0] OSDP_HIGH_RST   = 32'h0000_0000;
  localparam logic [31:0] OSDP_STEP_RST   = 32'h0000_0000;
  localparam logic        OSDP_INV_RST    = 1'b1;

  // shortest portion a coarse step may leave, in source cycles
  localparam logic [OSDP_LEN_W-1:0] OSDP_MIN_PORTION = 34'h0_0000_0002;
  localparam logic [OSDP_LEN_W-1:0] OSDP_LEN_ONE     = 34'h0_0000_0001;

  typedef struct packed {
    logic [OSDP_RATIO_W-1:0] ratio;
    logic [OSDP_RATIO_W-1:0] highWidth;
    logic [OSDP_RATIO_W-1:0] coarseStep;
    logic                    invertComp;
  } osdp_cfg_s;

  typedef struct packed {
    logic [OSDP_ADDR_W-1:0] addr;
    logic [OSDP_DATA_W-1:0] wdata;
    logic                   wr;
    logic                   rd;
  } osdp_req_s;

endpackage : osdp_pkg

// File: osdp_output_stage.sv
/*
  Dual output stage: per path integer divider, high-width shaping,
  coarse phase stepping and complement inversion, with its register
  port. Assumes clk is the fractional source clock and that register
  requests come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module osdp_output_stage
  import osdp_pkg::*;
#(
  parameter int NUM_PATHS = OSDP_NUM_PATHS
) (
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic                 clkEn,
  input  wire osdp_req_s            regReq,
  output logic [OSDP_DATA_W-1:0]    regRdata,
  output logic [NUM_PATHS-1:0]      trueOutput,
  output logic [NUM_PATHS-1:0]      complementOutput
);

  typedef logic signed [OSDP_LEN_W:0] osdp_slen_t;

  osdp_cfg_s                 cfg_ff      [NUM_PATHS];
  logic [NUM_PATHS-1:0]      stepPend_ff;
  logic [NUM_PATHS-1:0]      highPhase_ff;
  logic [OSDP_LEN_W-1:0]     cnt_ff      [NUM_PATHS];
  logic [OSDP_LEN_W-1:0]     curHigh_ff  [NUM_PATHS];
  logic [OSDP_LEN_W-1:0]     curLow_ff   [NUM_PATHS];
  logic [OSDP_DATA_W-1:0]    rdata_ff;
  logic [OSDP_DATA_W-1:0]    nxt_rdata;
  logic [NUM_PATHS-1:0]      trueOut_ff;
  logic [NUM_PATHS-1:0]      compOut_ff;

  logic [7:0]                ofs;
  logic [7:0]                pathSel;

  assign ofs     = regReq.addr & OSDP_OFS_MASK;
  assign pathSel = 8'(regReq.addr >> OSDP_PATH_LSB);

  // identical paths, all on the one source clock [RULE_01]
  for (genvar p = 0; p < NUM_PATHS; p++) begin : gPath
    logic                  wrHit;
    logic [OSDP_LEN_W-1:0] baseHigh;
    logic [OSDP_LEN_W-1:0] baseLow;
    logic [OSDP_LEN_W-1:0] ratioLen;
    osdp_slen_t            stepS;
    osdp_slen_t            adjHigh;
    osdp_slen_t            adjLow;
    osdp_slen_t            sumHigh;
    osdp_slen_t            sumLow;
    logic [OSDP_LEN_W-1:0] floorHigh;
    logic [OSDP_LEN_W-1:0] floorLow;
    logic [OSDP_LEN_W-1:0] nxt_high;
    logic [OSDP_LEN_W-1:0] nxt_low;
    logic                  endHigh;
    logic                  endLow;
    logic                  periodEnd;
    logic                  nxt_phase;

    assign wrHit = regReq.wr && (pathSel == 8'(p));

    // register writes
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        cfg_ff[p].ratio      <= OSDP_RATIO_RST;
        cfg_ff[p].highWidth  <= OSDP_HIGH_RST;
        cfg_ff[p].coarseStep <= OSDP_STEP_RST;
        cfg_ff[p].invertComp <= OSDP_INV_RST;
      end else if (clkEn && wrHit) begin
        case (ofs)
          OSDP_OFS_RATIO: cfg_ff[p].ratio      <= regReq.wdata; // [RULE_02]
          OSDP_OFS_HIGH:  cfg_ff[p].highWidth  <= regReq.wdata; // [RULE_07]
          OSDP_OFS_STEP:  cfg_ff[p].coarseStep <= regReq.wdata; // [RULE_08]
          OSDP_OFS_CTRL:  cfg_ff[p].invertComp <= regReq.wdata[OSDP_CTRL_INV_BIT];
          default: ;
        endcase
      end
    end

    // ratio zero treated as one
    assign ratioLen = (cfg_ff[p].ratio == '0) ? OSDP_LEN_ONE
                                              : OSDP_LEN_W'(cfg_ff[p].ratio);

    // base portions for the programmed duty
    always_comb begin
      if (cfg_ff[p].highWidth == '0) begin
        baseHigh = ratioLen - (ratioLen >> 1);                       // [RULE_03]
        baseLow  = ratioLen >> 1;                                    // [RULE_03]
      end else begin
        baseHigh = OSDP_LEN_W'(cfg_ff[p].highWidth);                 // [RULE_04]
        baseLow  = ratioLen - OSDP_LEN_W'(cfg_ff[p].highWidth);      // [RULE_05]
      end
    end

    // split of the pending coarse step, at most 2^32 per portion [RULE_11]
    always_comb begin
      stepS = stepPend_ff[p] ? osdp_slen_t'($signed(cfg_ff[p].coarseStep)) : '0;
      if (cfg_ff[p].highWidth == '0) begin
        adjHigh = stepS >>> 1;                                       // [RULE_13]
        adjLow  = stepS - adjHigh;                                   // [RULE_13]
      end else begin
        adjHigh = '0;                                                // [RULE_14]
        adjLow  = stepS;                                             // [RULE_14]
      end
      sumHigh = osdp_slen_t'({1'b0, baseHigh}) + adjHigh;            // [RULE_12]
      sumLow  = osdp_slen_t'({1'b0, baseLow}) + adjLow;              // [RULE_12]
    end

    // shortening stops at two cycles, never lengthens a short base [RULE_09]
    assign floorHigh = (baseHigh < OSDP_MIN_PORTION) ? baseHigh : OSDP_MIN_PORTION;
    assign floorLow  = (baseLow < OSDP_MIN_PORTION) ? baseLow : OSDP_MIN_PORTION;

    always_comb begin
      if (sumHigh < osdp_slen_t'({1'b0, floorHigh})) begin
        nxt_high = floorHigh;                                        // [RULE_09]
      end else begin
        nxt_high = sumHigh[OSDP_LEN_W-1:0];
      end
      if (sumLow < osdp_slen_t'({1'b0, floorLow})) begin
        nxt_low = floorLow;                                          // [RULE_09]
      end else begin
        nxt_low = sumLow[OSDP_LEN_W-1:0];
      end
    end

    assign endHigh = highPhase_ff[p] && (cnt_ff[p] >= curHigh_ff[p]);
    assign endLow  = !highPhase_ff[p] && (cnt_ff[p] >= curLow_ff[p]);

    // ratio one never enters low; its boundary is the end of high [RULE_17]
    assign periodEnd = endLow || (endHigh && curLow_ff[p] == '0);

    // step request: a new write wins over the boundary clear [RULE_18]
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        stepPend_ff[p] <= 1'b0;
      end else if (clkEn) begin
        if (wrHit && ofs == OSDP_OFS_STEP) begin
          stepPend_ff[p] <= 1'b1;                                    // [RULE_18]
        end else if (periodEnd) begin
          stepPend_ff[p] <= 1'b0;                                    // [RULE_18]
        end
      end
    end

    // period lengths latched once per period boundary [RULE_12]
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        curHigh_ff[p] <= OSDP_LEN_ONE;
        curLow_ff[p]  <= OSDP_LEN_ONE;
      end else if (clkEn && periodEnd) begin
        curHigh_ff[p] <= nxt_high;                                   // [RULE_08]
        curLow_ff[p]  <= nxt_low;                                    // [RULE_08]
      end
    end

    // high first, then low, counting source cycles [RULE_17]
    always_comb begin
      nxt_phase = highPhase_ff[p];
      if (periodEnd) begin
        nxt_phase = 1'b1;                                            // [RULE_17]
      end else if (endHigh) begin
        nxt_phase = 1'b0;                                            // [RULE_17]
      end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        highPhase_ff[p] <= 1'b0;
        cnt_ff[p]       <= OSDP_LEN_ONE;
      end else if (clkEn) begin
        highPhase_ff[p] <= nxt_phase;
        if (periodEnd || endHigh) begin
          cnt_ff[p] <= OSDP_LEN_ONE;                                 // [RULE_17]
        end else begin
          cnt_ff[p] <= cnt_ff[p] + OSDP_LEN_ONE;                     // [RULE_02]
        end
      end
    end

    // outputs from flops; pulses high-going on the true output [RULE_06]
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        trueOut_ff[p] <= 1'b0;
        compOut_ff[p] <= 1'b0;
      end else if (clkEn) begin
        trueOut_ff[p] <= nxt_phase;                                  // [RULE_06]
        compOut_ff[p] <= nxt_phase ^ cfg_ff[p].invertComp;           // [RULE_16]
      end
    end
  end : gPath

  // read mux, data one cycle after the strobe
  always_comb begin
    nxt_rdata = '0;
    for (int i = 0; i < NUM_PATHS; i++) begin
      if (regReq.rd && pathSel == 8'(i)) begin
        case (ofs)
          OSDP_OFS_RATIO:  nxt_rdata = cfg_ff[i].ratio;
          OSDP_OFS_HIGH:   nxt_rdata = cfg_ff[i].highWidth;
          OSDP_OFS_STEP:   nxt_rdata = cfg_ff[i].coarseStep;
          OSDP_OFS_CTRL:   nxt_rdata[OSDP_CTRL_INV_BIT] = cfg_ff[i].invertComp;
          OSDP_OFS_STATUS: begin
            nxt_rdata[OSDP_STAT_PEND_BIT]  = stepPend_ff[i];
            nxt_rdata[OSDP_STAT_LEVEL_BIT] = trueOut_ff[i];
          end
          default:         nxt_rdata = '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_ff <= '0;
    end else if (clkEn) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign regRdata         = rdata_ff;
  assign trueOutput       = trueOut_ff;
  assign complementOutput = compOut_ff;

endmodule : osdp_output_stage

`default_nettype wire

// File: osdp_output_stage_properties.sv
/* Port checker for the dual output stage.
   Assumes it is bound onto osdp_output_stage. */
`timescale 1ns/1ps
`default_nettype none
module osdp_output_stage_properties
  import osdp_pkg::*;
#(parameter int NUM_PATHS = OSDP_NUM_PATHS) (
  input wire logic                   clk,
  input wire logic                   sys_rst,
  input wire logic                   clkEn,
  input wire osdp_req_s              regReq,
  input wire logic [OSDP_DATA_W-1:0] regRdata,
  input wire logic [NUM_PATHS-1:0]   trueOutput,
  input wire logic [NUM_PATHS-1:0]   complementOutput
);
  logic anyWr_ff;
  // set once software has issued a write to any address
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) anyWr_ff <= 1'b0;
    else if (clkEn && regReq.wr) anyWr_ff <= 1'b1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_relLow; $fell(sys_rst) |-> trueOutput == '0 && regRdata == '0; endproperty
  a_relLow: assert property (p_relLow) else $error("outputs not low at release");
  property p_relHigh; $fell(sys_rst) && clkEn |=> trueOutput == '1 && complementOutput == '0;
  endproperty
  a_relHigh: assert property (p_relHigh) else $error("no high start");
  property p_freeze; !clkEn |=> $stable(trueOutput) && $stable(complementOutput); endproperty
  a_freeze: assert property (p_freeze) else $error("moved while disabled");
  property p_rdIdle; clkEn && !regReq.rd |=> regRdata == '0; endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data without read");
  property p_rdUnmap; clkEn && regReq.rd && regReq.addr[7:5] >= NUM_PATHS |=> regRdata == '0;
  endproperty
  a_rdUnmap: assert property (p_rdUnmap) else $error("unmapped read not zero");
  property p_toggle; !anyWr_ff && clkEn && !sys_rst |=> $changed(trueOutput[0]); endproperty
  a_toggle: assert property (p_toggle) else $error("reset ratio not toggling");
  property p_same; !anyWr_ff |-> trueOutput[0] == trueOutput[1]; endproperty
  a_same: assert property (p_same) else $error("paths differ");
  property p_comp; $changed(complementOutput) |-> $changed(trueOutput) || $past(regReq.wr, 2);
  endproperty
  a_comp: assert property (p_comp) else $error("complement moved alone");
endmodule : osdp_output_stage_properties
bind osdp_output_stage osdp_output_stage_properties #(.NUM_PATHS(NUM_PATHS))
  i_osdp_output_stage_properties (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn),
  .regReq(regReq), .regRdata(regRdata), .trueOutput(trueOutput),
  .complementOutput(complementOutput));
`default_nettype wire

// File: osdp_clk_receiver.sv
/* Downstream receiver: measures high and low run lengths.
   Assumes its level is sampled on the source clock. */
`timescale 1ns/1ps
`default_nettype none
module osdp_clk_receiver (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        level,
  output logic [31:0]      highLen,
  output logic [31:0]      lowLen,
  output logic             highDone,
  output logic             lowDone
);
  logic        prev_ff;
  logic [31:0] cnt_ff;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_ff  <= 1'b0;
      cnt_ff   <= '0;
      highLen  <= '0;
      lowLen   <= '0;
      highDone <= 1'b0;
      lowDone  <= 1'b0;
    end else begin
      prev_ff  <= level;
      cnt_ff   <= (level == prev_ff) ? cnt_ff + 32'h1 : 32'h1;
      highDone <= prev_ff && !level;
      lowDone  <= !prev_ff && level;
      if (prev_ff && !level) highLen <= cnt_ff;
      if (!prev_ff && level) lowLen <= cnt_ff;
    end
  end
endmodule : osdp_clk_receiver
`default_nettype wire

// File: tb_osdp_output_stage.sv
/* Bench for the dual output stage.
   Assumes a 200 MHz source clock and the one-cycle register port. */
`timescale 1ns/1ps
`default_nettype none
module tb_osdp_output_stage import osdp_pkg::*;;
  logic                   clk, sys_rst, clkEn;
  osdp_req_s              regReq;
  logic [OSDP_DATA_W-1:0] regRdata;
  logic [1:0]             trueOutput, complementOutput, highDone, lowDone;
  logic [1:0][31:0]       highLen, lowLen;
  int                     errors, comparisons, cycles;
  osdp_output_stage #(.NUM_PATHS(2)) i_osdp_output_stage (.clk(clk), .sys_rst(sys_rst),
    .clkEn(clkEn), .regReq(regReq), .regRdata(regRdata), .trueOutput(trueOutput),
    .complementOutput(complementOutput));
  osdp_clk_receiver i_osdp_clk_receiver [1:0] (.clk(clk), .sys_rst(sys_rst),
    .level(trueOutput), .highLen(highLen), .lowLen(lowLen), .highDone(highDone),
    .lowDone(lowDone));
  task automatic end_sim;
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    regReq.wr <= 1'b0;
  endtask : wr
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk);
    regReq <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    regReq.rd <= 1'b0;
    @(negedge clk);
    chk(regRdata & m, e);
  endtask : rdChk
  task automatic sync;
    do @(negedge clk); while (lowDone[0] !== 1'b1);
  endtask : sync
  task automatic per(input int p, input logic [31:0] h, input logic [31:0] l);
    do @(negedge clk); while (highDone[p] !== 1'b1);
    chk(highLen[p], h);
    do @(negedge clk); while (lowDone[p] !== 1'b1);
    chk(lowLen[p], l);
  endtask : per
  // one step on path 0: adjusted period, then back to base
  task automatic step(input logic [31:0] v, h, l, bh, bl);
    sync();
    wr(8'h08, v);
    rdChk(8'h10, 32'h1, 32'h1);
    per(0, h, l);
    per(0, bh, bl);
    $display("test step done");
  endtask : step
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      end_sim();
    end
  end
  initial begin
    {sys_rst, clkEn, regReq, errors, comparisons, cycles} = '0;
    sys_rst = 1'b1;
    clkEn = 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rdChk(8'h00, 32'h0000_0002, '1);
    rdChk(8'h24, 32'h0000_0000, '1);
    rdChk(8'h2C, 32'h0000_0001, '1);
    wr(8'h40, 32'h0000_0005);
    rdChk(8'h40, 32'h0000_0000, '1);
    $display("test regs done");
    wr(8'h00, 32'h0000_0007);
    wr(8'h20, 32'h0000_0007);
    sync();
    sync();
    per(0, 32'h4, 32'h3);
    per(1, 32'h4, 32'h3);
    wr(8'h00, 32'h0000_0008);
    sync();
    sync();
    step(32'h4, 32'h6, 32'h6, 32'h4, 32'h4);
    per(1, 32'h4, 32'h3);
    step(32'hFFFF_FFFD, 32'h2, 32'h3, 32'h4, 32'h4);
    wr(8'h00, 32'h0000_000A);
    wr(8'h04, 32'h0000_0003);
    sync();
    sync();
    per(0, 32'h3, 32'h7);
    sync();
    rdChk(8'h10, 32'h0000_0002, 32'h0000_0003);
    step(32'h4, 32'h3, 32'hB, 32'h3, 32'h7);
    step(32'hFFFF_FFEC, 32'h3, 32'h2, 32'h3, 32'h7);
    wr(8'h0C, 32'h0000_0000);
    sync();
    sync();
    repeat (6) begin
      @(negedge clk);
      chk(32'(complementOutput), 32'(trueOutput ^ 2'b10));
    end
    @(posedge clk) clkEn <= 1'b0;
    repeat (3) @(posedge clk);
    clkEn <= 1'b1;
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rdChk(8'h00, 32'h0000_0002, '1);
    $display("test rerun done");
    end_sim();
  end
endmodule : tb_osdp_output_stage
`default_nettype wire
